// [rtl/tx_synth_clock_control.sv]
// Reference clock divider, power mode, oscillator and synthesizer control behind the SPI slave port
`timescale 1ns/10ps
`default_nettype none

module tx_synth_clock_control
	import tx_synth_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic spi_clk_i,
	input wire logic spi_sel_b_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire logic regulator_status_above_1v3_i,
	input wire logic regulator_status_above_2v3_i,
	input wire logic vco_lock_i,
	output logic ref_clock_out_o,
	output logic osc_enable_o,
	output logic regulator_enable_o,
	output logic [3:0] osc_transconductance_o,
	output logic [5:0] osc_tuning_cap_o,
	output logic [31:0] carrier_word_o,
	output logic band_select_o,
	output logic [1:0] loop_filter_sel_o,
	output logic [2:0] charge_pump_current_o,
	output logic [3:0] vco_range_o,
	output logic ranging_busy_o
);
	import tx_synth_pkg::*;

	typedef struct packed {
		logic rst_meta;
		logic rst_sync_b;
	} rst_s;

	typedef struct packed {
		logic [14:0] shift;
		logic [15:0] cmd;
		logic req_tgl;
	} link_s;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic [1:0] regulator_status_s1;
		logic [1:0] regulator_status_s2;
		logic [1:0] regulator_status_prev;
		logic lock_s1;
		logic lock_s2;
		logic [3:0] power_mode;
		logic [1:0] regulator_status_sticky;
		logic [3:0] osc_gm;
		logic [5:0] osc_cap;
		logic [31:0] cw_pri;
		logic [31:0] cw_sec;
		logic [1:0] loop_flt;
		logic [2:0] loop_cpi;
		logic band_sel;
		logic carrier_sel;
		logic [3:0] pin_div;
		logic pin_disable;
		rng_state_e rng_state;
		logic [3:0] rng_val;
		logic rng_err;
		logic [15:0] settle_cnt;
		logic [7:0] rd_hold;
		logic [10:0] div_cnt;
		logic ref_out;
		logic ref_bypass;
		logic [31:0] cw_out;
		logic osc_en;
		logic regulator_status_en;
	} sys_s;

	localparam sys_s SYS_RST = '{
		req_s1: 1'b0, req_s2: 1'b0, req_seen: 1'b0,
		regulator_status_s1: 2'h0, regulator_status_s2: 2'h0, regulator_status_prev: 2'h0,
		lock_s1: 1'b0, lock_s2: 1'b0,
		power_mode: POWER_MODE_RST, regulator_status_sticky: 2'h0,
		osc_gm: OSC_GM_RST, osc_cap: OSC_CAP_RST,
		cw_pri: CARRIER_WORD_RST, cw_sec: CARRIER_WORD_RST,
		loop_flt: LOOP_FLT_RST, loop_cpi: LOOP_CPI_RST,
		band_sel: 1'b0, carrier_sel: 1'b0,
		pin_div: PIN_DIV_RST, pin_disable: PIN_DISABLE_RST,
		rng_state: RNG_IDLE, rng_val: 4'h0, rng_err: 1'b0,
		settle_cnt: 16'h0000, rd_hold: 8'h00,
		div_cnt: 11'h000, ref_out: 1'b0, ref_bypass: 1'b0,
		cw_out: CARRIER_WORD_RST, osc_en: 1'b0, regulator_status_en: 1'b0
	};

	localparam logic [15:0] SETTLE_LAST = 16'(RANGE_SETTLE_CYC - 1);
	localparam logic [3:0] DIV_CODE_MAX = 4'(DIV_LOG2_MAX);
	localparam logic [3:0] FRAME_LAST = 4'(SPI_FRAME_BITS - 1);

	rst_s r;
	rst_s next_r;
	link_s l;
	link_s next_l;
	sys_s s;
	sys_s next_s;
	logic [3:0] bit_cnt;
	logic frame_rst_b;
	logic ref_gate;

	// Reset release through two flip-flops
	always_comb begin
		next_r.rst_meta = 1'b1;
		next_r.rst_sync_b = r.rst_meta;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Link side: bit counter cleared whenever select is high
	assign frame_rst_b = r.rst_sync_b & ~spi_sel_b_i;

	always_ff @(posedge spi_clk_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			bit_cnt <= 4'h0;
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Shift in command and data, publish whole frame with a toggle
	always_comb begin
		next_l = l;
		next_l.shift = {l.shift[13:0], spi_mosi_i};
		if (bit_cnt == FRAME_LAST) begin
			next_l.cmd = {l.shift, spi_mosi_i};
			next_l.req_tgl = ~l.req_tgl;
		end
	end

	always_ff @(posedge spi_clk_i or negedge r.rst_sync_b) begin
		if (!r.rst_sync_b) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// Read data shifted out on the falling edge during the data byte
	always_ff @(negedge spi_clk_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			spi_miso_o <= 1'b0;
			spi_miso_oe_o <= 1'b0;
		end else begin
			spi_miso_oe_o <= 1'b1;
			spi_miso_o <= bit_cnt[3] ? s.rd_hold[~bit_cnt[2:0]] : 1'b0;
		end
	end

	// System side
	always_comb begin
		logic frame;
		logic is_wr;
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [1:0] drop;
		logic [3:0] div_log;
		logic soft_rst;
		frame = 1'b0;
		is_wr = 1'b0;
		addr = 7'h00;
		wdata = 8'h00;
		drop = 2'h0;
		div_log = 4'h0;
		soft_rst = 1'b0;
		next_s = s;

		next_s.req_s1 = l.req_tgl;
		next_s.req_s2 = s.req_s1;
		next_s.req_seen = s.req_s2;
		next_s.regulator_status_s1 = {regulator_status_above_2v3_i, regulator_status_above_1v3_i};
		next_s.regulator_status_s2 = s.regulator_status_s1;
		next_s.regulator_status_prev = s.regulator_status_s2;
		next_s.lock_s1 = vco_lock_i;
		next_s.lock_s2 = s.lock_s1;

		frame = s.req_s2 != s.req_seen;
		is_wr = l.cmd[15];
		addr = l.cmd[14:8];
		wdata = l.cmd[7:0];

		// Sticky drop flags, cleared by reading status; a new drop wins
		drop = s.regulator_status_prev & ~s.regulator_status_s2;
		if (frame && !is_wr && addr == ADDR_REG_STATUS) begin
			next_s.regulator_status_sticky = 2'h0;
		end
		next_s.regulator_status_sticky = next_s.regulator_status_sticky | drop;

		// Range search: step through ranges until the loop locks or range 15 fails to lock
		unique case (s.rng_state)
			RNG_IDLE: begin
				next_s.settle_cnt = 16'h0000;
			end
			RNG_SETTLE: begin
				next_s.settle_cnt = s.settle_cnt + 16'h0001;
				if (s.settle_cnt == SETTLE_LAST) begin
					next_s.rng_state = RNG_CHECK;
				end
			end
			RNG_CHECK: begin
				next_s.settle_cnt = 16'h0000;
				if (s.lock_s2) begin
					next_s.rng_err = 1'b0;
					next_s.rng_state = RNG_IDLE;
				end else if (s.rng_val == 4'hf) begin
					next_s.rng_err = 1'b1;
					next_s.rng_state = RNG_IDLE;
				end else begin
					next_s.rng_val = s.rng_val + 4'h1;
					next_s.rng_state = RNG_SETTLE;
				end
			end
		endcase

		if (frame) begin
			if (is_wr) begin
				if (addr == ADDR_POWER_STATE) begin
					next_s.power_mode = wdata[PS_MODE_LSB +: 4];
					soft_rst = wdata[PS_SOFT_RST_BIT];
				end
				if (addr == ADDR_OSC_CONTROL) begin
					next_s.osc_gm = wdata[3:0];
				end
				if (addr == ADDR_OSC_CAP) begin
					next_s.osc_cap = wdata[5:0];
				end
				if (addr[6:2] == ADDR_CW_PRIMARY[6:2]) begin
					next_s.cw_pri[{~addr[1:0], 3'b000} +: 8] = wdata;
				end
				if (addr[6:2] == ADDR_CW_SECONDARY[6:2]) begin
					next_s.cw_sec[{~addr[1:0], 3'b000} +: 8] = wdata;
				end
				if (addr == ADDR_SYNTH_LOOP) begin
					next_s.loop_flt = wdata[LOOP_FLT_LSB +: 2];
					next_s.loop_cpi = wdata[LOOP_CPI_LSB +: 3];
					next_s.band_sel = wdata[LOOP_BAND_BIT];
					next_s.carrier_sel = wdata[LOOP_SEL_BIT];
				end
				if (addr == ADDR_VCO_RANGE && wdata[RANGING_START_BIT] && s.rng_state == RNG_IDLE) begin
					next_s.rng_val = 4'h0;
					next_s.rng_err = 1'b0;
					next_s.settle_cnt = 16'h0000;
					next_s.rng_state = RNG_SETTLE;
				end
				if (addr == ADDR_PIN_CONFIG) begin
					next_s.pin_div = wdata[PIN_DIV_LSB +: 4];
					next_s.pin_disable = wdata[PIN_DISABLE_BIT];
				end
			end
			// Register value before this frame's write lands
			unique case (addr)
				ADDR_POWER_STATE: next_s.rd_hold = {4'h0, s.power_mode};
				ADDR_REG_STATUS: next_s.rd_hold = {4'h0, s.regulator_status_sticky, s.regulator_status_s2};
				ADDR_OSC_CONTROL: next_s.rd_hold = {4'h0, s.osc_gm};
				ADDR_OSC_CAP: next_s.rd_hold = {2'h0, s.osc_cap};
				7'h20: next_s.rd_hold = s.cw_pri[31:24];
				7'h21: next_s.rd_hold = s.cw_pri[23:16];
				7'h22: next_s.rd_hold = s.cw_pri[15:8];
				7'h23: next_s.rd_hold = s.cw_pri[7:0];
				7'h24: next_s.rd_hold = s.cw_sec[31:24];
				7'h25: next_s.rd_hold = s.cw_sec[23:16];
				7'h26: next_s.rd_hold = s.cw_sec[15:8];
				7'h27: next_s.rd_hold = s.cw_sec[7:0];
				ADDR_SYNTH_LOOP: next_s.rd_hold = {s.carrier_sel, 1'b0, s.band_sel, s.loop_cpi, s.loop_flt};
				ADDR_VCO_RANGE: next_s.rd_hold = {2'h0, s.rng_err, s.rng_state != RNG_IDLE, s.rng_val};
				ADDR_PIN_CONFIG: next_s.rd_hold = {s.pin_disable, 3'h0, s.pin_div};
				default: next_s.rd_hold = 8'h00;
			endcase
		end

		// Reference clock divider, ratio 2^code capped at 2048
		next_s.div_cnt = s.div_cnt + 11'h001;
		div_log = (next_s.pin_div > DIV_CODE_MAX) ? DIV_CODE_MAX : next_s.pin_div;
		if (next_s.pin_disable) begin
			next_s.ref_out = 1'b0;
			next_s.ref_bypass = 1'b0;
		end else if (div_log == 4'h0) begin
			next_s.ref_out = 1'b0;
			next_s.ref_bypass = 1'b1;
		end else begin
			next_s.ref_bypass = 1'b0;
			next_s.ref_out = next_s.div_cnt[div_log - 4'h1];
		end

		next_s.osc_en = next_s.power_mode != MODE_POWERDOWN;
		next_s.regulator_status_en = next_s.power_mode == MODE_SYNTH_TX || next_s.power_mode == MODE_FULL_TX;
		next_s.cw_out = next_s.carrier_sel ? next_s.cw_sec : next_s.cw_pri;

		if (soft_rst) begin
			next_s = SYS_RST;
			next_s.req_s1 = l.req_tgl;
			next_s.req_s2 = s.req_s1;
			next_s.req_seen = s.req_s2;
			next_s.regulator_status_s1 = {regulator_status_above_2v3_i, regulator_status_above_1v3_i};
			next_s.regulator_status_s2 = s.regulator_status_s1;
			next_s.regulator_status_prev = s.regulator_status_s2;
		end
	end

	always_ff @(posedge clock_i or negedge r.rst_sync_b) begin
		if (!r.rst_sync_b) begin
			s <= SYS_RST;
		end else begin
			s <= next_s;
		end
	end

	// Ratio one passes the input clock through a registered gate
	assign ref_gate = clock_i & s.ref_bypass;

	assign ref_clock_out_o = s.ref_out | ref_gate;
	assign osc_enable_o = s.osc_en;
	assign regulator_enable_o = s.regulator_status_en;
	assign osc_transconductance_o = s.osc_gm;
	assign osc_tuning_cap_o = s.osc_cap;
	assign carrier_word_o = s.cw_out;
	assign band_select_o = s.band_sel;
	assign loop_filter_sel_o = s.loop_flt;
	assign charge_pump_current_o = s.loop_cpi;
	assign vco_range_o = s.rng_val;
	assign ranging_busy_o = s.rng_state != RNG_IDLE;

endmodule

`default_nettype wire

// [rtl/tx_synth_pkg.sv]
// Constants, register map and state codes of the transmitter clock and synthesizer control block
package tx_synth_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int RANGE_SETTLE_NS = 10000;
	localparam int RANGE_SETTLE_CYC = (RANGE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SPI_FRAME_BITS = 16;

	// Register addresses (7-bit SPI address space)
	localparam logic [6:0] ADDR_POWER_STATE = 7'h02;
	localparam logic [6:0] ADDR_REG_STATUS = 7'h03;
	localparam logic [6:0] ADDR_OSC_CONTROL = 7'h10;
	localparam logic [6:0] ADDR_OSC_CAP = 7'h11;
	localparam logic [6:0] ADDR_CW_PRIMARY = 7'h20;
	localparam logic [6:0] ADDR_CW_SECONDARY = 7'h24;
	localparam logic [6:0] ADDR_SYNTH_LOOP = 7'h2c;
	localparam logic [6:0] ADDR_VCO_RANGE = 7'h2d;
	localparam logic [6:0] ADDR_PIN_CONFIG = 7'h30;

	// Field positions
	localparam int PS_MODE_LSB = 0;
	localparam int PS_SOFT_RST_BIT = 7;
	localparam int LOOP_FLT_LSB = 0;
	localparam int LOOP_CPI_LSB = 2;
	localparam int LOOP_BAND_BIT = 5;
	localparam int LOOP_SEL_BIT = 7;
	localparam int RNG_VAL_LSB = 0;
	localparam int RANGING_START_BIT = 4;
	localparam int RNG_ERR_BIT = 5;
	localparam int PIN_DIV_LSB = 0;
	localparam int PIN_DISABLE_BIT = 7;

	// Power modes
	localparam logic [3:0] MODE_POWERDOWN = 4'h0;
	localparam logic [3:0] MODE_STANDBY = 4'h5;
	localparam logic [3:0] MODE_SYNTH_TX = 4'hc;
	localparam logic [3:0] MODE_FULL_TX = 4'hd;

	// Reset values
	localparam logic [3:0] POWER_MODE_RST = 4'h0;
	localparam logic [3:0] OSC_GM_RST = 4'h8;
	localparam logic [5:0] OSC_CAP_RST = 6'h00;
	localparam logic [31:0] CARRIER_WORD_RST = 32'h0000_0000;
	localparam logic [1:0] LOOP_FLT_RST = 2'h1;
	localparam logic [2:0] LOOP_CPI_RST = 3'h2;
	localparam logic [3:0] PIN_DIV_RST = 4'h0;
	localparam logic PIN_DISABLE_RST = 1'b1;

	// Largest divider is 2 to this power
	localparam int DIV_LOG2_MAX = 11;

	typedef enum logic [2:0] {
		RNG_IDLE = 3'b001,
		RNG_SETTLE = 3'b010,
		RNG_CHECK = 3'b100
	} rng_state_e;

endpackage

// [sim/spi_host_model.sv]
// Host microcontroller model: SPI master sending 16-bit frames
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
	output logic sclk_o,
	output logic sel_b_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		sel_b_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Clock runs only inside the frame, 32 ns period
	task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
		sel_b_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = frame[i];
			#16 sclk_o = 1'b1;
			if (i < 8) begin
				rd[i] = miso_i;
			end
			#16 sclk_o = 1'b0;
		end
		#16 sel_b_o = 1'b1;
		mosi_o = ~mosi_o;
		#300;
	endtask
endmodule

`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the reference clock and synthesizer control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import tx_synth_pkg::*;
	logic clock_i, rst_b_i, sclk, sel_b, mosi, miso_d, miso_oe, v13, v23, lock;
	logic ref_clk, osc_en, reg_en, band, busy;
	logic [3:0] gm, rng;
	logic [5:0] cap;
	logic [31:0] cw;
	logic [1:0] loop_filter_sel;
	logic [2:0] cpi;
	logic [7:0] v;
	wire miso_w;
	int err_count = 0;
	int checks = 0;

	assign miso_w = miso_oe ? miso_d : 1'bz;

	tx_synth_clock_control dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .spi_clk_i(sclk), .spi_sel_b_i(sel_b),
		.spi_mosi_i(mosi), .spi_miso_o(miso_d), .spi_miso_oe_o(miso_oe), .regulator_status_above_1v3_i(v13),
		.regulator_status_above_2v3_i(v23), .vco_lock_i(lock), .ref_clock_out_o(ref_clk), .osc_enable_o(osc_en),
		.regulator_enable_o(reg_en), .osc_transconductance_o(gm), .osc_tuning_cap_o(cap), .carrier_word_o(cw),
		.band_select_o(band), .loop_filter_sel_o(loop_filter_sel), .charge_pump_current_o(cpi), .vco_range_o(rng),
		.ranging_busy_o(busy));
	spi_host_model host_u (.sclk_o(sclk), .sel_b_o(sel_b), .mosi_o(mosi), .miso_i(miso_w));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		host_u.xfer({1'b1, a, d}, x);
	endtask

	// Answer comes in the following frame
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		logic [7:0] x;
		host_u.xfer({1'b0, a, 8'h00}, x);
		host_u.xfer({1'b0, a, 8'h00}, d);
	endtask

	task automatic give_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic t_regs;
		cmp("osc", 0, osc_en);
		cmp("regulator_status", 0, reg_en);
		rd(ADDR_PIN_CONFIG, v);
		cmp("pin", 8'h80, v);
		rd(7'h7f, v);
		cmp("unmapped", 0, v);
		wr(ADDR_SYNTH_LOOP, 8'h36);
		cmp("flt", 2, loop_filter_sel);
		cmp("cpi", 5, cpi);
		cmp("band", 1, band);
		for (int i = 0; i < 4; i++) begin
			wr(7'(ADDR_CW_PRIMARY + i), 8'(8'h11 * (i + 1)));
			wr(7'(ADDR_CW_SECONDARY + i), 8'(8'ha1 + 8'h11 * i));
		end
		cmp("cw1", 32'h11223344, cw);
		wr(ADDR_SYNTH_LOOP, 8'hb6);
		cmp("cw2", 32'ha1b2c3d4, cw);
		rd(ADDR_SYNTH_LOOP, v);
		cmp("loop", 8'hb6, v);
		wr(ADDR_OSC_CONTROL, 8'h03);
		wr(ADDR_OSC_CAP, 8'h2a);
		cmp("gm", 3, gm);
		cmp("cap", 6'h2a, cap);
		wr(ADDR_POWER_STATE, {4'h0, MODE_STANDBY});
		cmp("osc on", 1, osc_en);
		cmp("regulator_status off", 0, reg_en);
		wr(ADDR_POWER_STATE, {4'h0, MODE_FULL_TX});
		cmp("regulator_status on", 1, reg_en);
		wr(ADDR_POWER_STATE, 8'h80);
		cmp("gm rst", OSC_GM_RST, gm);
		cmp("cw rst", 0, cw);
		cmp("osc rst", 0, osc_en);
		rd(ADDR_SYNTH_LOOP, v);
		cmp("loop rst", {3'h0, LOOP_CPI_RST, LOOP_FLT_RST}, v);
		wr(ADDR_POWER_STATE, 8'h00);
	endtask

	task automatic t_div;
		int codes[4] = '{1, 3, 11, 15};
		int r;
		int h;
		int rises;
		logic p;
		wr(ADDR_PIN_CONFIG, 8'h00);
		@(posedge clock_i);
		#5 cmp("ratio1 hi", 1, ref_clk);
		@(negedge clock_i);
		#5 cmp("ratio1 lo", 0, ref_clk);
		foreach (codes[k]) begin
			r = 1 << (codes[k] > 11 ? 11 : codes[k]);
			wr(ADDR_PIN_CONFIG, 8'(codes[k]));
			repeat (r) @(negedge clock_i);
			h = 0;
			rises = 0;
			p = ref_clk;
			repeat (4 * r) begin
				@(negedge clock_i);
				h += (ref_clk === 1'b1);
				rises += (ref_clk === 1'b1 && p === 1'b0);
				p = ref_clk;
			end
			cmp("high cycles", 2 * r, h);
			cmp("rises", 4, rises);
		end
		wr(ADDR_PIN_CONFIG, 8'h83);
		h = 0;
		repeat (64) begin
			@(negedge clock_i);
			h += (ref_clk !== 1'b0);
		end
		cmp("disabled", 0, h);
	endtask

	task automatic t_regulator_status;
		@(posedge clock_i);
		v13 <= 1'b0;
		v23 <= 1'b0;
		repeat (5) @(posedge clock_i);
		v13 <= 1'b1;
		v23 <= 1'b1;
		repeat (5) @(posedge clock_i);
		rd(ADDR_REG_STATUS, v);
		cmp("sticky", 8'h0f, v);
		rd(ADDR_REG_STATUS, v);
		cmp("cleared", 8'h03, v);
	endtask

	task automatic ranging(input logic lk, input logic [7:0] e);
		@(posedge clock_i);
		lock <= lk;
		wr(ADDR_VCO_RANGE, 8'h10);
		cmp("busy", 1, busy);
		for (int i = 0; i < 5000 && busy === 1'b1; i++) @(posedge clock_i);
		cmp("idle", 0, busy);
		rd(ADDR_VCO_RANGE, v);
		cmp("ranging", e, v & 8'h30);
	endtask

	initial begin
		rst_b_i = 1'b0;
		v13 = 1'b1;
		v23 = 1'b1;
		lock = 1'b0;
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_regs();
		t_div();
		t_regulator_status();
		ranging(1'b1, 8'h00);
		cmp("range", 0, rng);
		ranging(1'b0, 8'h20);
		give_verdict();
	end

	initial begin
		#3000000;
		err_count++;
		give_verdict();
	end
endmodule

bind tx_synth_clock_control tx_synth_asserts chk_u (.*);

`default_nettype wire

// [sim/tx_synth_asserts.sv]
// Port-level checks of the clock and synthesizer control block
`timescale 1ns/10ps
`default_nettype none

module tx_synth_asserts
	import tx_synth_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic spi_sel_b_i,
	input wire logic spi_miso_oe_o,
	input wire logic vco_lock_i,
	input wire logic ref_clock_out_o,
	input wire logic osc_enable_o,
	input wire logic regulator_enable_o,
	input wire logic [3:0] osc_transconductance_o,
	input wire logic [31:0] carrier_word_o,
	input wire logic band_select_o,
	input wire logic [1:0] loop_filter_sel_o,
	input wire logic [2:0] charge_pump_current_o,
	input wire logic [3:0] vco_range_o,
	input wire logic ranging_busy_o
);
	localparam int BUSY_MAX = 16 * RANGE_SETTLE_CYC + 64;
	logic [12:0] busy_cnt;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	// Length of the current range search
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cnt <= 13'h0;
		end else begin
			busy_cnt <= ranging_busy_o ? busy_cnt + 13'h1 : 13'h0;
		end
	end

	a_miso_release: assert property (spi_sel_b_i && $past(spi_sel_b_i) |-> !spi_miso_oe_o)
		else $error("MISO driven while deselected");
	a_reset_power: assert property ($rose(rst_b_i) |-> !osc_enable_o && !regulator_enable_o && !ref_clock_out_o)
		else $error("power outputs not at defaults after reset");
	a_reset_synth: assert property ($rose(rst_b_i) |-> osc_transconductance_o == OSC_GM_RST &&
		loop_filter_sel_o == LOOP_FLT_RST && charge_pump_current_o == LOOP_CPI_RST &&
		carrier_word_o == CARRIER_WORD_RST && !band_select_o)
		else $error("synthesizer outputs not at defaults after reset");
	a_reg_needs_osc: assert property (regulator_enable_o |-> osc_enable_o)
		else $error("regulator on without oscillator");
	a_range_first: assert property ($rose(ranging_busy_o) |-> vco_range_o == 4'h0)
		else $error("range search did not start at range zero");
	a_busy_min: assert property ($rose(ranging_busy_o) |-> ranging_busy_o [*8])
		else $error("range search ended too early");
	a_range_step: assert property (ranging_busy_o && $past(ranging_busy_o) && vco_range_o != $past(vco_range_o)
		|-> vco_range_o == $past(vco_range_o) + 4'h1)
		else $error("range search skipped a range");
	a_lock_done: assert property ($rose(ranging_busy_o) && vco_lock_i |-> ##[1:260] !ranging_busy_o)
		else $error("locked range search did not finish");
	a_busy_bound: assert property (busy_cnt <= BUSY_MAX)
		else $error("range search ran too long");
endmodule

`default_nettype wire
